/* include/pmwp_pkg.sv */
// shared constants for the phy management write port
package pmwp_pkg;
  // ========================================
  // register map, loader side
  localparam logic [11:0] PHY_WRITE_VALUE_OFS = 12'h0A4;
  localparam logic [11:0] PHY_WRITE_LAUNCH_OFS = 12'h0A8;
  localparam logic [15:0] PHY_WRITE_VALUE_RST = 16'h0000;
  // ========================================
  // launch register fields
  localparam int PHY_ADDR_MSB = 15;
  localparam int PHY_ADDR_LSB = 11;
  localparam int REG_INDEX_MSB = 10;
  localparam int REG_INDEX_LSB = 6;
  localparam int MUST_ONE_BIT = 1;
  localparam logic [4:0] FIELD5_RST = 5'h00;
  // ========================================
  // management frame, clause 22 write
  localparam logic [1:0] FRM_START = 2'h1;
  localparam logic [1:0] FRM_OP_WRITE = 2'h1;
  localparam logic [1:0] FRM_TURN = 2'h2;
  localparam int PREAMBLE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam logic [6:0] FRAME_LAST = 7'h3F;
  // management clock: 2.5 MHz from a 100 MHz core clock
  localparam int CORE_CLK_MHZ = 100;
  localparam int MDC_MAX_MHZ_X10 = 25;
  localparam int MDC_HALF_CYCLES = (CORE_CLK_MHZ * 10 + 2 * MDC_MAX_MHZ_X10 - 1)
                                   / (2 * MDC_MAX_MHZ_X10);
  localparam logic [7:0] MDC_HALF_LAST = 8'(MDC_HALF_CYCLES - 1);
endpackage

/* src/pmwp_phy_mgmt_write_port.sv */
// loader-only indirect write path to the integrated phy management bus
`timescale 1ns/1ps
`default_nettype none
module pmwp_phy_mgmt_write_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration loader write port
  input wire logic ldr_wr,
  input wire logic [11:0] ldr_addr,
  input wire logic [31:0] ldr_wdata,
  output logic ldr_busy,
  // management bus toward the phys
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe
);
  // ========================================
  // state
  typedef enum logic [0:0] {
    PMWP_IDLE = 1'b0,
    PMWP_SHIFT = 1'b1
  } pmwp_state_t;

  // last preamble bit; the command word is loaded behind it
  localparam logic [6:0] PRE_LAST = 7'(pmwp_pkg::PREAMBLE_BITS - 1);

  // sequencer state
  pmwp_state_t state_reg, state_next;
  logic [6:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] div_reg, div_next;
  logic mdc_reg, mdc_next;
  // loader visible fields and the frame copy of the value
  logic [15:0] value_reg, value_next;
  logic [15:0] frame_data_reg, frame_data_next;
  logic [4:0] phy_addr_reg, phy_addr_next;
  logic [4:0] target_reg_index_reg, target_reg_index_next;
  // serialiser
  logic [31:0] shift_reg, shift_next;
  logic mdio_reg, mdio_next;
  logic oe_reg, oe_next;
  logic [31:0] cmd_word;
  logic half_tick;
  logic rise_tick;
  logic fall_tick;
  logic last_bit;
  logic value_wr;
  logic launch_wr;

  // ========================================
  // decode and strobes
  // only the loader port reaches these; no host path exists in this block
  assign value_wr = ldr_wr && (ldr_addr == pmwp_pkg::PHY_WRITE_VALUE_OFS);
  // a launch while a frame is out is dropped; the loader must wait on busy
  assign launch_wr = ldr_wr && (ldr_addr == pmwp_pkg::PHY_WRITE_LAUNCH_OFS)
                     && (state_reg == PMWP_IDLE);
  assign half_tick = (state_reg == PMWP_SHIFT) && (div_reg == pmwp_pkg::MDC_HALF_LAST);
  assign rise_tick = half_tick && !mdc_reg;
  assign fall_tick = half_tick && mdc_reg;
  assign last_bit = (bit_cnt_reg == pmwp_pkg::FRAME_LAST);
  // write opcode only: this port never reads a phy
  assign cmd_word = {pmwp_pkg::FRM_START, pmwp_pkg::FRM_OP_WRITE, phy_addr_reg,
                     target_reg_index_reg, pmwp_pkg::FRM_TURN, frame_data_reg};

  // ========================================
  // value register
  always_comb begin
    value_next = value_reg;
    if (value_wr) begin
      // reserved bits 31:16 are dropped
      value_next = ldr_wdata[15:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value_reg <= pmwp_pkg::PHY_WRITE_VALUE_RST;
    end else begin
      value_reg <= value_next;
    end
  end

  // ========================================
  // launch fields
  always_comb begin
    phy_addr_next = phy_addr_reg;
    target_reg_index_next = target_reg_index_reg;
    frame_data_next = frame_data_reg;
    if (launch_wr) begin
      // reserved launch bits, bit 1 included, are not looked at
      phy_addr_next = ldr_wdata[pmwp_pkg::PHY_ADDR_MSB:pmwp_pkg::PHY_ADDR_LSB];
      target_reg_index_next =
        ldr_wdata[pmwp_pkg::REG_INDEX_MSB:pmwp_pkg::REG_INDEX_LSB];
      // staged value is copied now, so a rewrite while busy cannot reach this frame
      frame_data_next = value_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phy_addr_reg <= pmwp_pkg::FIELD5_RST;
      target_reg_index_reg <= pmwp_pkg::FIELD5_RST;
      frame_data_reg <= pmwp_pkg::PHY_WRITE_VALUE_RST;
    end else begin
      phy_addr_reg <= phy_addr_next;
      target_reg_index_reg <= target_reg_index_next;
      frame_data_reg <= frame_data_next;
    end
  end

  // ========================================
  // frame sequencer
  // mdc is divided down from the core clock; 64 bits at two half periods each
  always_comb begin
    state_next = state_reg;
    div_next = div_reg;
    bit_cnt_next = bit_cnt_reg;
    mdc_next = mdc_reg;
    unique case (state_reg)
      PMWP_IDLE: begin
        // mdc stands still between frames
        div_next = 8'h00;
        bit_cnt_next = 7'h00;
        mdc_next = 1'b0;
        if (launch_wr) begin
          state_next = PMWP_SHIFT;
        end
      end
      PMWP_SHIFT: begin
        div_next = half_tick ? 8'h00 : 8'(div_reg + 8'h01);
        if (rise_tick) begin
          // phy samples here, half a period after the data moved
          mdc_next = 1'b1;
        end
        if (fall_tick) begin
          mdc_next = 1'b0;
          if (last_bit) begin
            state_next = PMWP_IDLE;
          end else begin
            bit_cnt_next = 7'(bit_cnt_reg + 7'h01);
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PMWP_IDLE;
      bit_cnt_reg <= 7'h00;
      div_reg <= 8'h00;
      mdc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      div_reg <= div_next;
      mdc_reg <= mdc_next;
    end
  end

  // ========================================
  // data out
  // mdio only moves at the launch and on the falling mdc edge, so it is settled at every rising edge
  always_comb begin
    shift_next = shift_reg;
    mdio_next = mdio_reg;
    oe_next = oe_reg;
    if (state_reg == PMWP_IDLE) begin
      mdio_next = 1'b0;
      oe_next = 1'b0;
      if (launch_wr) begin
        // first preamble bit goes out with the launch, ahead of the first rising mdc
        mdio_next = 1'b1;
        oe_next = 1'b1;
      end
    end else if (fall_tick) begin
      if (last_bit) begin
        // no idle bits are appended; the line is let go at once
        mdio_next = 1'b0;
        oe_next = 1'b0;
      end else if (bit_cnt_reg == PRE_LAST) begin
        // the latched fields are read only here, once the preamble is out
        mdio_next = cmd_word[31];
        shift_next = {cmd_word[30:0], 1'b0};
      end else if (bit_cnt_reg > PRE_LAST) begin
        mdio_next = shift_reg[31];
        shift_next = {shift_reg[30:0], 1'b0};
      end else begin
        mdio_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 32'h00000000;
      mdio_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      mdio_reg <= mdio_next;
      oe_reg <= oe_next;
    end
  end

  // ========================================
  // outputs
  // busy comes straight from state so the loader sees it one cycle after a launch
  assign ldr_busy = (state_reg == PMWP_SHIFT);
  assign mdc = mdc_reg;
  assign mdio_o = mdio_reg;
  assign mdio_oe = oe_reg;
endmodule
`default_nettype wire

/* verification/pmwp_checker.sv */
// assertions on the phy management write port
`timescale 1ns/1ps
`default_nettype none
module pmwp_checker (
  // watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ldr_wr,
  input wire logic [11:0] ldr_addr,
  input wire logic [31:0] ldr_wdata,
  input wire logic ldr_busy,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  // ========
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic go = ldr_wr && ldr_addr == pmwp_pkg::PHY_WRITE_LAUNCH_OFS && !ldr_busy;
  chk_launch_busy: assert property (go |=> ldr_busy) else $error("no start");
  chk_value_only: assert property (ldr_wr && !ldr_busy
    && ldr_addr == pmwp_pkg::PHY_WRITE_VALUE_OFS |=> !ldr_busy) else $error("bad start");
  chk_first_bit: assert property ($rose(ldr_busy) |-> ##20 mdc && mdio_oe && mdio_o)
    else $error("bad first bit");
  chk_mdc_half: assert property ($rose(mdc) |-> ##20 $fell(mdc)) else $error("bad mdc");
  chk_data_hold: assert property ($rose(mdc) |=> $stable(mdio_o) [*8])
    else $error("mdio moved");
  chk_oe_busy: assert property (mdio_oe |-> ldr_busy) else $error("stray oe");
  chk_end_release: assert property ($fell(ldr_busy) |-> !mdio_oe) else $error("oe held");
  chk_idle_quiet: assert property (!ldr_busy && !$past(ldr_busy) |-> !mdc && !mdio_oe)
    else $error("idle noise");
  cover property (go);
  cover property ($fell(ldr_busy));
  cover property (ldr_wr && ldr_busy);
endmodule
`default_nettype wire

/* verification/pmwp_phy_model.sv */
// phy side model collecting management write frames
`timescale 1ns/1ps
`default_nettype none
module pmwp_phy_model (
  // management bus
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  // captured frame
  output logic [63:0] frame,
  output int nbits
);
  initial frame = '0;
  initial nbits = 0;
  // phy samples on the rising management clock
  always @(posedge mdc) if (mdio_oe) begin
    frame <= {frame[62:0], mdio_o};
    nbits <= nbits + 1;
  end
endmodule
`default_nettype wire

/* verification/pmwp_phy_mgmt_write_port_tb_top.sv */
// self-checking bench for the phy management write port
`timescale 1ns/1ps
`default_nettype none
module pmwp_phy_mgmt_write_port_tb_top;
  // ========
  // signals
  logic core_clk = 1'b0, rst = 1'b1, ldr_wr = 1'b0, ldr_busy, mdc, mdio_o, mdio_oe;
  logic [11:0] ldr_addr = 12'h000;
  logic [31:0] ldr_wdata = 32'h00000000;
  logic [63:0] frame;
  logic [15:0] d;
  logic [4:0] a, r;
  int err_count = 0, checks = 0, cyc = 0, nbits, n0;
  pmwp_phy_mgmt_write_port u_pmwp_phy_mgmt_write_port(.core_clk, .rst, .ldr_wr, .ldr_addr,
    .ldr_wdata, .ldr_busy, .mdc, .mdio_o, .mdio_oe);
  pmwp_phy_model u_pmwp_phy_model(.mdc, .mdio_o, .mdio_oe, .frame, .nbits);
  initial forever #5 core_clk = ~core_clk;
  // four frames take about 10260 cycles
  always @(posedge core_clk) if (++cyc == 20000) begin
    err_count++;
    end_sim();
  end
  task end_sim;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp_frame(logic [63:0] got, logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_count(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe stays high across back-to-back writes
  task wr(logic [11:0] ad, logic [31:0] wd);
    ldr_wr = 1;
    ldr_addr = ad;
    ldr_wdata = wd;
    @(posedge core_clk) #1;
  endtask
  function logic [63:0] exp_frame(logic [4:0] pa, logic [4:0] ri, logic [15:0] v);
    return {32'hFFFFFFFF, 4'h5, pa, ri, 2'h2, v};
  endfunction
  initial begin
    void'($urandom(32'hC9592E21));
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    for (int i = 0; i < 4; i++) begin
      d = i ? 16'($urandom) : 16'h0000;
      a = i == 1 ? 5'h1F : 5'($urandom);
      r = 5'($urandom);
      if (i > 0) wr(12'h0A4, {16'($urandom), d});
      n0 = nbits;
      wr(12'h0A8, {16'($urandom), a, r, 4'($urandom), 1'b1, 1'($urandom)});
      wr(12'h0A4, $urandom);
      wr(12'h0A8, $urandom | 2);
      wr(12'h0AC, $urandom);
      ldr_wr = 0;
      for (int n = 0; n < 3000 && ldr_busy !== 1'b0; n++) @(posedge core_clk);
      #1 cmp_frame(frame, exp_frame(a, r, d));
      cmp_count(32'(nbits - n0), 32'h00000040);
    end
    end_sim();
  end
endmodule
bind pmwp_phy_mgmt_write_port pmwp_checker u_pmwp_checker(.core_clk, .rst, .ldr_wr, .ldr_addr,
  .ldr_wdata, .ldr_busy, .mdc, .mdio_o, .mdio_oe);
`default_nettype wire
